// ---- fxc_correlator.sv ----
// fx correlator datapath for one quadrant: delay, transform, requantize, correlate, integrate
// Notes on behaviour
// (RULE1) full band in, 524288 channels, 3.815 kHz apart
// (RULE2) 2^20-point transform, keep 2^19 channels only
// (RULE3) 16-bit spectra requantized to 4-bit complex
// (RULE4) 3-bit samples in; multiply only 4-bit spectra
// (RULE5) delay-compensate each antenna before the transform
// (RULE6) eight time slices, results averaged together
// (RULE7) trim output to a selectable channel window
// (RULE8) cross spectrum for every antenna pair
// (RULE9) auto spectra through the same multiplier
// (RULE10) cross-polarization products only when enabled
// (RULE11) polarimetry gives parallel and orthogonal products
// (RULE12) channel-average and time-integrate as configured
// (RULE13) send integrated results to downstream processors
// (RULE14) one baseband pair per quadrant, sixteen antennas; this datapath takes two antennas
// (RULE15) back ends send eight streams per antenna
// (RULE16) upstream samples at 4 GHz, 3-bit codes
// (RULE17) no water-vapour correction applied
// (RULE18) cross channel is first times conjugate second
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module fxc_correlator #(
  parameter int unsigned FRAME_LEN = fxc_pkg::FXC_TRANSFORM_POINTS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_valid,
  input wire logic [2:0] link_a0_x,
  input wire logic [2:0] link_a0_y,
  input wire logic [2:0] link_a1_x,
  input wire logic [2:0] link_a1_y,
  output logic fibre_valid,
  output logic [2:0] fibre_prod,
  output logic [18:0] fibre_chan,
  output logic [31:0] fibre_re,
  output logic [31:0] fibre_im
);
  // whole module state, registered once per clock
  typedef struct packed {
    fxc_pkg::fxc_state_t st;
    logic en;                        // software run enable
    logic pol;                       // polarimetry option
    logic [3:0] dly0;                // antenna 0 delay in samples
    logic [3:0] dly1;                // antenna 1 delay in samples
    logic [18:0] win_lo;             // first channel of the window
    logic [18:0] win_hi;             // last channel of the window
    logic [2:0] bin_log;             // log2 of channels per bin
    logic [7:0] int_grp;             // integration length less one, in groups of eight frames
    logic [3:0] rq;                  // requantizer shift
    logic [3:0][15:0][2:0] dline;    // per-stream delay lines
    logic [3:0][31:0] acc_re;        // transform accumulators
    logic [3:0][31:0] acc_im;
    logic [19:0] phase;              // twiddle phase of the current channel
    logic [20:0] smp;                // samples taken in this frame
    logic [10:0] frame;              // frames taken for this channel
    logic [18:0] chan;               // channel under transform
    logic [18:0] grp_chan;           // first channel of the current bin
    logic [4:0] bin_cnt;             // channels summed into the bin
    logic [7:0][31:0] sum_re;        // integrated products
    logic [7:0][31:0] sum_im;
    logic [7:0][31:0] eb_re;         // emit buffer, lets integration go on
    logic [7:0][31:0] eb_im;
    logic [18:0] e_chan;
    logic e_pol;
    logic [2:0] e_idx;
    logic e_busy;
    logic o_valid;
    logic [2:0] o_prod;
    logic [18:0] o_chan;
    logic [31:0] o_re;
    logic [31:0] o_im;
    logic ack;                       // bus answer pulse
    logic [31:0] rdata;
    logic [31:0] count;              // bins sent downstream
  } fxc_regs_t;

  fxc_regs_t r;
  fxc_regs_t next_r;

  // 3-bit code to odd level -7..7
  function automatic logic signed [3:0] fxc_level(input logic [2:0] c);
    fxc_level = $signed({c, 1'b1}) - 4'sh8; // RULE4
  endfunction : fxc_level

  // cosine of the coarse twiddle phase, scaled to 127
  function automatic logic signed [7:0] fxc_cos(input logic [2:0] p);
    unique case (p)
      3'h0: fxc_cos = 8'sh7f;
      3'h1, 3'h7: fxc_cos = 8'sh5a;
      3'h2, 3'h6: fxc_cos = 8'sh00;
      3'h3, 3'h5: fxc_cos = 8'sha6;
      3'h4: fxc_cos = 8'sh81;
    endcase
  endfunction : fxc_cos

  // 16-bit spectrum to 4-bit with saturation; clipping beats wrap-around
  function automatic logic signed [3:0] fxc_q4(input logic signed [15:0] v, input logic [3:0] sh);
    logic signed [15:0] s;
    s = v >>> sh;
    if (s > 16'sh0007) fxc_q4 = 4'sh7;
    else if (s < -16'sh0008) fxc_q4 = -4'sh8;
    else fxc_q4 = s[3:0];
  endfunction : fxc_q4

  // a times conjugate b, real and imaginary parts sign-extended
  function automatic logic [63:0] fxc_xconj(input logic signed [3:0] ar, input logic signed [3:0] ai,
                                            input logic signed [3:0] br, input logic signed [3:0] bi);
    logic signed [8:0] re;
    logic signed [8:0] im;
    // widen before multiplying: a 4-bit product would wrap
    re = 9'(ar) * 9'(br) + 9'(ai) * 9'(bi);
    im = 9'(ai) * 9'(br) - 9'(ar) * 9'(bi);
    fxc_xconj = {{23{re[8]}}, re, {23{im[8]}}, im}; // RULE18
  endfunction : fxc_xconj

  // byte-lane merge for writes
  function automatic logic [31:0] fxc_merge(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      fxc_merge[b*8 +: 8] = be[b] ? d[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction : fxc_merge

  // product pair table: autos, parallel cross, then orthogonal cross
  function automatic logic [3:0] fxc_pair(input logic [2:0] i);
    unique case (i)
      3'h0: fxc_pair = {2'h0, 2'h0};
      3'h1: fxc_pair = {2'h1, 2'h1};
      3'h2: fxc_pair = {2'h2, 2'h2};
      3'h3: fxc_pair = {2'h3, 2'h3};
      3'h4: fxc_pair = {2'h0, 2'h2};
      3'h5: fxc_pair = {2'h1, 2'h3};
      3'h6: fxc_pair = {2'h0, 2'h3};
      3'h7: fxc_pair = {2'h1, 2'h2};
    endcase
  endfunction : fxc_pair

  localparam logic [20:0] LAST_SMP = 21'(FRAME_LEN - 1);

  // all next-state logic in one process
  always_comb begin
    logic [3:0][2:0] raw;
    logic signed [3:0] lv;
    logic signed [7:0] c;
    logic signed [7:0] s;
    logic [3:0] dsel;
    logic [3:0][3:0] qre;
    logic [3:0][3:0] qim;
    logic [3:0] pr;
    logic [63:0] p;
    logic [31:0] w;
    logic frame_end;
    logic grp_end;
    logic bin_end;
    next_r = r;
    raw = {link_a1_y, link_a1_x, link_a0_y, link_a0_x}; // RULE14
    lv = '0;
    c = '0;
    s = '0;
    dsel = '0;
    qre = '0;
    qim = '0;
    pr = '0;
    p = '0;
    w = '0;
    frame_end = 1'b0;
    grp_end = 1'b0;
    bin_end = 1'b0;
    next_r.ack = 1'b0;
    next_r.o_valid = 1'b0;
    // bus slave: one wait cycle, then the answer
    if ((avs_read || avs_write) && !r.ack) begin
      next_r.ack = 1'b1;
      next_r.rdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          fxc_pkg::FXC_REG_CTRL: next_r.rdata = {30'h0, r.pol, r.en};
          fxc_pkg::FXC_REG_DELAY: next_r.rdata = {24'h0, r.dly1, r.dly0};
          fxc_pkg::FXC_REG_WIN_LO: next_r.rdata = {13'h0, r.win_lo};
          fxc_pkg::FXC_REG_WIN_HI: next_r.rdata = {13'h0, r.win_hi};
          fxc_pkg::FXC_REG_BIN: next_r.rdata = {29'h0, r.bin_log};
          fxc_pkg::FXC_REG_INT: next_r.rdata = {24'h0, r.int_grp};
          fxc_pkg::FXC_REG_RQ: next_r.rdata = {28'h0, r.rq};
          fxc_pkg::FXC_REG_STATUS: next_r.rdata = {28'h0, r.e_busy, r.st};
          fxc_pkg::FXC_REG_CHAN: next_r.rdata = {13'h0, r.chan};
          fxc_pkg::FXC_REG_COUNT: next_r.rdata = r.count;
          default: next_r.rdata = '0; // unmapped reads as zero
        endcase
      end
    end
    // write lands at the edge where the master sees waitrequest low
    if (avs_write && r.ack) begin
      begin
        unique case (avs_address)
          fxc_pkg::FXC_REG_CTRL: begin
            w = fxc_merge({30'h0, r.pol, r.en}, avs_writedata, avs_byteenable);
            next_r.en = w[fxc_pkg::FXC_CTRL_EN_BIT];
            next_r.pol = w[fxc_pkg::FXC_CTRL_POL_BIT];
          end
          fxc_pkg::FXC_REG_DELAY: begin
            w = fxc_merge({24'h0, r.dly1, r.dly0}, avs_writedata, avs_byteenable);
            next_r.dly0 = w[3:0];
            next_r.dly1 = w[fxc_pkg::FXC_DELAY_A1_LSB +: 4];
          end
          fxc_pkg::FXC_REG_WIN_LO: begin
            w = fxc_merge({13'h0, r.win_lo}, avs_writedata, avs_byteenable);
            next_r.win_lo = w[18:0]; // RULE2 channels above 2^19-1 cannot be named
          end
          fxc_pkg::FXC_REG_WIN_HI: begin
            w = fxc_merge({13'h0, r.win_hi}, avs_writedata, avs_byteenable);
            next_r.win_hi = w[18:0];
          end
          fxc_pkg::FXC_REG_BIN: begin
            w = fxc_merge({29'h0, r.bin_log}, avs_writedata, avs_byteenable);
            // bin factors of 1 to 16 only
            next_r.bin_log = (w[2:0] > fxc_pkg::FXC_MAX_BIN_LOG) ? fxc_pkg::FXC_MAX_BIN_LOG : w[2:0];
          end
          fxc_pkg::FXC_REG_INT: begin
            w = fxc_merge({24'h0, r.int_grp}, avs_writedata, avs_byteenable);
            next_r.int_grp = (w[7:0] == 8'h00) ? 8'h01 : w[7:0];
          end
          fxc_pkg::FXC_REG_RQ: begin
            w = fxc_merge({28'h0, r.rq}, avs_writedata, avs_byteenable);
            next_r.rq = w[3:0];
          end
          default: ; // read-only and unmapped writes are dropped
        endcase
      end
    end
    // emit buffer drains one product per clock; cross-pol skipped unless latched on
    if (r.e_busy) begin
      next_r.o_valid = 1'b1;
      next_r.o_prod = r.e_idx;
      next_r.o_chan = r.e_chan;
      next_r.o_re = r.eb_re[r.e_idx]; // RULE13
      next_r.o_im = r.eb_im[r.e_idx];
      next_r.e_idx = r.e_idx + 3'h1;
      if (r.e_idx == 3'h7 || (r.e_idx == 3'h5 && !r.e_pol)) begin // RULE10
        next_r.e_busy = 1'b0;
        next_r.e_idx = 3'h0;
      end
    end
    // run control
    unique case (r.st)
      fxc_pkg::FXC_IDLE: begin
        if (r.en) begin
          next_r.st = fxc_pkg::FXC_RUN;
          next_r.chan = r.win_lo; // RULE7
          next_r.grp_chan = r.win_lo;
          next_r.phase = '0;
          next_r.smp = '0;
          next_r.frame = '0;
          next_r.bin_cnt = '0;
          next_r.acc_re = '0;
          next_r.acc_im = '0;
          next_r.sum_re = '0;
          next_r.sum_im = '0;
        end
      end
      fxc_pkg::FXC_RUN: begin
        if (!r.en) begin
          next_r.st = fxc_pkg::FXC_DRAIN; // partial bin is discarded
        end else if (link_valid) begin
          frame_end = (r.smp == LAST_SMP);
          c = fxc_cos(r.phase[19:17]);
          s = fxc_cos(r.phase[19:17] - 3'h2);
          for (int k = 0; k < 4; k++) begin
            next_r.dline[k] = {r.dline[k][14:0], raw[k]};
            dsel = (k < 2) ? r.dly0 : r.dly1;
            // delayed sample taken before it enters the transform
            lv = fxc_level((dsel == 4'h0) ? raw[k] : r.dline[k][dsel - 4'h1]); // RULE5
            // x times e^-j(phase): real += x cos, imag -= x sin
            // widen first so the level times twiddle product cannot wrap
            next_r.acc_re[k] = r.acc_re[k] + 32'(12'(lv) * 12'(c)); // RULE1
            next_r.acc_im[k] = r.acc_im[k] - 32'(12'(lv) * 12'(s));
          end
          // channel k advances phase by k/2^20 turns per sample
          next_r.phase = r.phase + {1'b0, r.chan}; // RULE2
          next_r.smp = r.smp + 21'h1;
          if (frame_end) begin
            for (int k = 0; k < 4; k++) begin
              // the upper 16 bits are the transform output
              qre[k] = fxc_q4(next_r.acc_re[k][31:16], r.rq); // RULE3
              qim[k] = fxc_q4(next_r.acc_im[k][31:16], r.rq);
            end
            for (int i = 0; i < 8; i++) begin
              pr = fxc_pair(3'(i));
              // autos and crosses share one multiplier form
              p = fxc_xconj(qre[pr[3:2]], qim[pr[3:2]], qre[pr[1:0]], qim[pr[1:0]]); // RULE8 RULE9
              if (i < 6 || r.pol) begin // RULE10 RULE11
                next_r.sum_re[i] = r.sum_re[i] + p[63:32]; // RULE12
                next_r.sum_im[i] = r.sum_im[i] + p[31:0];
              end
            end
            next_r.acc_re = '0;
            next_r.acc_im = '0;
            next_r.phase = '0;
            next_r.smp = '0;
            next_r.frame = r.frame + 11'h1;
            // frames go round the eight slices; a group is one frame per slice
            grp_end = (r.frame == {r.int_grp, 3'h7}); // RULE6
            if (grp_end) begin
              next_r.frame = '0;
              next_r.bin_cnt = r.bin_cnt + 5'h1;
              next_r.chan = (r.chan >= r.win_hi) ? r.win_lo : r.chan + 19'h1; // RULE7
              bin_end = (r.bin_cnt == 5'((5'h1 << r.bin_log) - 5'h1)) || (r.chan >= r.win_hi);
              if (bin_end) begin
                // slice average: eight slices per group, divide by eight
                for (int i = 0; i < 8; i++) begin
                  next_r.eb_re[i] = 32'(signed'(next_r.sum_re[i]) >>> fxc_pkg::FXC_SLICE_LOG); // RULE6
                  next_r.eb_im[i] = 32'(signed'(next_r.sum_im[i]) >>> fxc_pkg::FXC_SLICE_LOG);
                end
                next_r.e_chan = r.grp_chan;
                next_r.e_pol = r.pol;
                next_r.e_busy = 1'b1;
                next_r.e_idx = 3'h0;
                next_r.count = r.count + 32'h1;
                next_r.sum_re = '0;
                next_r.sum_im = '0;
                next_r.bin_cnt = '0;
                next_r.grp_chan = next_r.chan;
              end
            end
          end
        end
      end
      fxc_pkg::FXC_DRAIN: begin
        if (!r.e_busy) next_r.st = fxc_pkg::FXC_IDLE;
      end
      default: next_r.st = fxc_pkg::FXC_IDLE; // illegal codes recover
    endcase
  end

  // single state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= fxc_pkg::FXC_IDLE;
      r.dly0 <= fxc_pkg::FXC_RST_DELAY;
      r.dly1 <= fxc_pkg::FXC_RST_DELAY;
      r.win_lo <= fxc_pkg::FXC_RST_WIN_LO;
      r.win_hi <= fxc_pkg::FXC_RST_WIN_HI;
      r.bin_log <= fxc_pkg::FXC_RST_BIN;
      r.int_grp <= fxc_pkg::FXC_RST_INT;
      r.rq <= fxc_pkg::FXC_RST_RQ;
    end else begin
      r <= next_r;
    end
  end

  // ports; handshake is combinational, data from flops
  assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
  assign avs_readdata = r.rdata;
  assign fibre_valid = r.o_valid;
  assign fibre_prod = r.o_prod;
  assign fibre_chan = r.o_chan;
  assign fibre_re = r.o_re; // RULE17
  assign fibre_im = r.o_im;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence fxc_par_tail;
    fibre_valid && fibre_prod == 3'h5;
  endsequence
  sequence fxc_orth_pair;
    fibre_valid && fibre_prod == 3'h6 ##1 fibre_valid && fibre_prod == 3'h7;
  endsequence

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  pol_gate_a: assert property (fibre_valid && fibre_prod[2:1] == 2'h3 |-> $past(r.e_pol)) // RULE10
    else $error("cross-pol product while disabled");
  orth_full_a: assert property (fxc_par_tail ##0 r.e_pol |=> fxc_orth_pair) // RULE11
    else $error("orthogonal products missing");
  auto_real_a: assert property (fibre_valid && !fibre_prod[2] |-> fibre_im == 32'h0) // RULE9
    else $error("auto spectrum not real");
  auto_sign_a: assert property (fibre_valid && !fibre_prod[2] |-> !fibre_re[31]) // RULE9
    else $error("auto spectrum negative");
  phase_step_a: assert property (r.st == fxc_pkg::FXC_RUN && r.en && link_valid && r.smp != LAST_SMP
      |=> r.phase == $past(r.phase) + {1'b0, $past(r.chan)}) // RULE1
    else $error("twiddle step wrong");
  frame_wrap_a: assert property (r.st == fxc_pkg::FXC_RUN && r.en && link_valid && r.smp == LAST_SMP
      |=> r.smp == 21'h0 && r.phase == 20'h0) // RULE2
    else $error("frame did not restart");
  emit_order_a: assert property (fibre_valid && fibre_prod == 3'h0
      |=> fibre_valid && fibre_prod == 3'h1 ##1 fibre_valid ##1 fibre_valid) // RULE13
    else $error("emit sequence broken");
  group_step_a: assert property (r.st == fxc_pkg::FXC_RUN && r.en && link_valid && r.smp == LAST_SMP
      && r.frame == {r.int_grp, 3'h7} |=> r.frame == 11'h0) // RULE6
    else $error("slice group did not close");
endmodule : fxc_correlator

// ---- fxc_far_side.sv ----
// upstream sample source standing in for the antenna back ends
`timescale 1ns/1ps
module fxc_far_side (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run, // stream samples while high
  input wire logic [3:0] skew, // samples by which antenna 1 leads antenna 0
  output logic link_valid,
  output logic [2:0] link_a0_x,
  output logic [2:0] link_a0_y,
  output logic [2:0] link_a1_x,
  output logic [2:0] link_a1_y
);
  logic [3:0] phase; // sample index, period equals the short bench frame

  // fixed code sequence; any 3-bit value is one of the eight levels
  function automatic logic [2:0] code(input logic [3:0] i);
    code = 3'((i * 4'h5) + 4'h3);
  endfunction : code

  // four streams of one baseband pair per sample, both polarizations of both antennas
  // antenna 1 runs ahead by skew samples, as an uncompensated geometric delay would
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 4'h0;
      link_valid <= 1'b0;
      {link_a0_x, link_a0_y, link_a1_x, link_a1_y} <= 12'h000;
    end else if (run) begin
      phase <= phase + 4'h1;
      link_valid <= 1'b1;
      link_a0_x <= code(phase);
      link_a0_y <= code(phase + 4'h5);
      link_a1_x <= code(phase + skew);
      link_a1_y <= code(phase + skew + 4'h5);
    end else begin
      // idle lines toggle so stale codes are never mistaken for samples
      link_valid <= 1'b0;
      {link_a0_x, link_a0_y, link_a1_x, link_a1_y} <=
        ~{link_a0_x, link_a0_y, link_a1_x, link_a1_y};
    end
  end
endmodule : fxc_far_side

// ---- fxc_pkg.sv ----
// constants, register map and state codes of the fx correlator datapath
package fxc_pkg;
  // transform geometry: full-band points and the kept half of the spectrum
  localparam int unsigned FXC_TRANSFORM_POINTS = 1048576;
  localparam int unsigned FXC_SPECTRUM_CHANNELS = 524288;
  localparam real FXC_CH_SPACING_KHZ = 3.815;
  localparam int unsigned FXC_SLICES = 8;
  localparam int unsigned FXC_SLICE_LOG = 3;
  localparam int unsigned FXC_PRODUCTS = 8;
  localparam int unsigned FXC_DELAY_TAPS = 16;
  // register byte offsets
  localparam logic [5:0] FXC_REG_CTRL = 6'h00;
  localparam logic [5:0] FXC_REG_DELAY = 6'h04;
  localparam logic [5:0] FXC_REG_WIN_LO = 6'h08;
  localparam logic [5:0] FXC_REG_WIN_HI = 6'h0c;
  localparam logic [5:0] FXC_REG_BIN = 6'h10;
  localparam logic [5:0] FXC_REG_INT = 6'h14;
  localparam logic [5:0] FXC_REG_RQ = 6'h18;
  localparam logic [5:0] FXC_REG_STATUS = 6'h1c;
  localparam logic [5:0] FXC_REG_CHAN = 6'h20;
  localparam logic [5:0] FXC_REG_COUNT = 6'h24;
  // control field positions
  localparam int unsigned FXC_CTRL_EN_BIT = 0;
  localparam int unsigned FXC_CTRL_POL_BIT = 1;
  localparam int unsigned FXC_DELAY_A1_LSB = 4;
  // values after reset, and the bin-size limit
  localparam logic [3:0] FXC_RST_DELAY = 4'h0;
  localparam logic [18:0] FXC_RST_WIN_LO = 19'h00000;
  localparam logic [18:0] FXC_RST_WIN_HI = 19'h7ffff;
  localparam logic [2:0] FXC_RST_BIN = 3'h1;
  localparam logic [7:0] FXC_RST_INT = 8'h01;
  localparam logic [3:0] FXC_RST_RQ = 4'h8;
  localparam logic [2:0] FXC_MAX_BIN_LOG = 3'h4;
  // one-hot run states
  typedef enum logic [2:0] {
    FXC_IDLE = 3'b001,
    FXC_RUN = 3'b010,
    FXC_DRAIN = 3'b100
  } fxc_state_t;
endpackage : fxc_pkg

// ---- tb.sv ----
// self-checking bench for the fx correlator datapath
`timescale 1ns/1ps
module tb;
  typedef struct {logic [5:0] a; logic wr; logic [31:0] wd; logic [31:0] exp;} fxc_row_t;
  typedef struct {logic [2:0] prod; logic [18:0] chan; logic [31:0] re; logic [31:0] im;} fxc_word_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, fibre_re, fibre_im, d;
  logic avs_waitrequest, link_valid, fibre_valid;
  logic far_run = 1'b0; // far side streams while high
  logic [2:0] link_a0_x, link_a0_y, link_a1_x, link_a1_y, fibre_prod;
  logic [18:0] fibre_chan;
  int fails = 0;
  int total_checks = 0;
  int bins_sent = 0; // bins the fibre has carried since reset
  fxc_word_t q[$]; // fibre words of the current run
  // register table: reset reads first, then write-and-read-back rows
  fxc_row_t rows [20] = '{
    '{fxc_pkg::FXC_REG_CTRL, 1'b0, 32'h0, 32'h0},
    '{fxc_pkg::FXC_REG_DELAY, 1'b0, 32'h0, 32'(fxc_pkg::FXC_RST_DELAY)},
    '{fxc_pkg::FXC_REG_WIN_LO, 1'b0, 32'h0, 32'(fxc_pkg::FXC_RST_WIN_LO)},
    '{fxc_pkg::FXC_REG_WIN_HI, 1'b0, 32'h0, 32'(fxc_pkg::FXC_RST_WIN_HI)},
    '{fxc_pkg::FXC_REG_BIN, 1'b0, 32'h0, 32'(fxc_pkg::FXC_RST_BIN)},
    '{fxc_pkg::FXC_REG_INT, 1'b0, 32'h0, 32'(fxc_pkg::FXC_RST_INT)},
    '{fxc_pkg::FXC_REG_RQ, 1'b0, 32'h0, 32'(fxc_pkg::FXC_RST_RQ)},
    '{fxc_pkg::FXC_REG_STATUS, 1'b0, 32'h0, 32'h1},
    '{fxc_pkg::FXC_REG_COUNT, 1'b0, 32'h0, 32'h0},
    '{6'h28, 1'b0, 32'h0, 32'h0},
    '{fxc_pkg::FXC_REG_BIN, 1'b1, 32'h7, 32'(fxc_pkg::FXC_MAX_BIN_LOG)},
    '{fxc_pkg::FXC_REG_INT, 1'b1, 32'h0, 32'h1},
    '{fxc_pkg::FXC_REG_STATUS, 1'b1, 32'hff, 32'h1},
    '{6'h2c, 1'b1, 32'h5, 32'h0},
    '{fxc_pkg::FXC_REG_COUNT, 1'b1, 32'h9, 32'h0},
    '{fxc_pkg::FXC_REG_WIN_LO, 1'b1, 32'h10, 32'h10},
    '{fxc_pkg::FXC_REG_WIN_HI, 1'b1, 32'h13, 32'h13},
    '{fxc_pkg::FXC_REG_BIN, 1'b1, 32'h1, 32'h1},
    '{fxc_pkg::FXC_REG_DELAY, 1'b1, 32'h30, 32'h30},
    '{fxc_pkg::FXC_REG_RQ, 1'b1, 32'h0, 32'h0}};

  // short frames keep a bin to a few hundred cycles
  fxc_correlator #(.FRAME_LEN(16)) dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_valid(link_valid), .link_a0_x(link_a0_x), .link_a0_y(link_a0_y),
    .link_a1_x(link_a1_x), .link_a1_y(link_a1_y), .fibre_valid(fibre_valid),
    .fibre_prod(fibre_prod), .fibre_chan(fibre_chan), .fibre_re(fibre_re), .fibre_im(fibre_im));
  // antenna 1 leads by three samples, matching the delay written below
  fxc_far_side far (.clk(clk), .rst_b(rst_b), .run(far_run), .skew(4'h3),
    .link_valid(link_valid), .link_a0_x(link_a0_x), .link_a0_y(link_a0_y),
    .link_a1_x(link_a1_x), .link_a1_y(link_a1_y));

  // 125 MHz clock
  always #4 clk = ~clk;

  // fibre sink: every word stands one cycle, so take it at that edge
  always @(posedge clk) begin
    if (fibre_valid === 1'b1) q.push_back('{fibre_prod, fibre_chan, fibre_re, fibre_im});
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_fib(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: fibre got %h expected %h", $time, got, exp);
    end
  endtask : chk_fib

  // bus cycle: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    // look at waitrequest mid-cycle, where it has settled
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    d = avs_readdata;
    @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // run until nb bins are out, stop, then check each bin's words
  task automatic run_bins(input logic pol, input int nb);
    int k, n, b, i;
    k = pol ? 8 : 6;
    q.delete();
    bus(1'b1, fxc_pkg::FXC_REG_CTRL, {30'h0, pol, 1'b1});
    far_run <= 1'b1;
    bus(1'b0, fxc_pkg::FXC_REG_STATUS, 32'h0);
    chk(d & 32'h7, 32'h2);
    n = 0;
    while (q.size() < nb * k && n < 5000) begin
      @(posedge clk);
      n++;
    end
    bus(1'b1, fxc_pkg::FXC_REG_CTRL, 32'h0);
    far_run <= 1'b0;
    repeat (20) @(posedge clk);
    chk_fib(q.size(), nb * k);
    if (q.size() < nb * k) return;
    for (b = 0; b < nb; b++) begin
      for (i = 0; i < k; i++) begin
        chk_fib(32'(q[b*k+i].prod), i);
        if (!pol) chk_fib(32'(q[b*k+i].chan), (b == 1) ? 32'h12 : 32'h10);
      end
      if (b > 0) begin
        chk_fib(q[b*k].im, 32'h0);
        chk_fib(q[b*k+1].im, 32'h0);
        chk_fib(q[b*k+2].re, q[b*k].re);
        chk_fib(q[b*k+4].re, q[b*k].re);
        chk_fib(q[b*k+4].im, 32'h0);
        chk_fib(q[b*k+5].re, q[b*k+1].re);
        if (pol) chk_fib(q[b*k+6].re, q[b*k+7].re);
        if (pol) chk_fib(q[b*k+6].im, -q[b*k+7].im);
      end
    end
    bins_sent += nb;
    bus(1'b0, fxc_pkg::FXC_REG_COUNT, 32'h0);
    chk(d, bins_sent);
  endtask : run_bins

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs a few thousand cycles
  initial begin
    #400000;
    fails++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // register table rows: reset reads, clamped, read-only and unmapped writes, read-backs
    foreach (rows[r]) begin
      if (rows[r].wr) bus(1'b1, rows[r].a, rows[r].wd);
      bus(1'b0, rows[r].a, 32'h0);
      chk(d, rows[r].exp);
    end
    $display("test registers done");
    // three bins: window of four channels, two per bin, the third bin wraps to the first channel
    run_bins(1'b0, 3);
    $display("test parallel products done");
    // polarimetry adds the two orthogonal products
    run_bins(1'b1, 2);
    $display("test polarimetry done");
    // reset in mid-run clears outputs and registers
    far_run <= 1'b1;
    bus(1'b1, fxc_pkg::FXC_REG_CTRL, 32'h3);
    repeat (200) @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    chk_fib({31'h0, fibre_valid}, 32'h0);
    rst_b <= 1'b1;
    far_run <= 1'b0;
    bus(1'b0, fxc_pkg::FXC_REG_WIN_HI, 32'h0);
    chk(d, 32'(fxc_pkg::FXC_RST_WIN_HI));
    bus(1'b0, fxc_pkg::FXC_REG_COUNT, 32'h0);
    chk(d, 32'h0);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb
